// ==== shared/tio_pkg.sv ====
// tio_pkg: constants, types and defaults for the tracker input/output trigger logic
package tio_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 3;
  localparam int CLK_HZ = 40_000_000;
  localparam int DEB_TIME_US = 100;
  localparam int DEB_CYCLES = (DEB_TIME_US * (CLK_HZ / 1_000_000) > 0) ? DEB_TIME_US * (CLK_HZ / 1_000_000) : 1;
  localparam int HOLD_TIME_S = 3;
  localparam int HOLD_CYCLES = HOLD_TIME_S * CLK_HZ;
  localparam int NUM_BAUD = 6;
  localparam int BAUD_RATE [NUM_BAUD] = '{4800, 9600, 19200, 38400, 57600, 115200};

  typedef enum logic [1:0] {
    TIO_ROLE_EMERG = 2'h0,
    TIO_ROLE_TEST = 2'h1,
    TIO_ROLE_GEN = 2'h2
  } tio_role_t;

  typedef enum logic [1:0] {
    TIO_TRIG_RISE = 2'h0,
    TIO_TRIG_FALL = 2'h1,
    TIO_TRIG_BOTH = 2'h2
  } tio_trig_t;

  typedef enum logic {
    TIO_SW_MOMENT = 1'h0,
    TIO_SW_LATCH = 1'h1
  } tio_sw_t;

  typedef enum logic [1:0] {
    TIO_BTN_UP = 2'h0,
    TIO_BTN_DOWN = 2'h1,
    TIO_BTN_LONG = 2'h3
  } tio_btn_t;

  // per-line role and trigger, written as one word by the host
  typedef struct packed {
    tio_role_t [NUM_IN-1:0] role;
    tio_trig_t [NUM_IN-1:0] trig;
  } tio_cfg_t;

  localparam tio_cfg_t TIO_CFG_DEFAULT = '{
    role: '{TIO_ROLE_GEN, TIO_ROLE_GEN, TIO_ROLE_TEST, TIO_ROLE_EMERG},
    trig: '{TIO_TRIG_FALL, TIO_TRIG_FALL, TIO_TRIG_FALL, TIO_TRIG_FALL}
  };
  localparam tio_sw_t TIO_SW_DEFAULT = TIO_SW_MOMENT;
  localparam logic TIO_PCR_DEFAULT = 1'h0;
  localparam logic [2:0] TIO_BAUD_DEFAULT = 3'h2;
  localparam logic [2:0] TIO_BAUD_MAX = 3'h5;
  localparam logic [NUM_OUT-1:0] TIO_OUT_DEFAULT = 3'h0;

  function automatic int baud_div(input int idx);
    return CLK_HZ / BAUD_RATE[idx];
  endfunction
endpackage

// ==== verilog/tio_trigger.sv ====
// tio_trigger: input triggers, emergency control, outputs and baud setting of the tracker connector
`timescale 1ns/10ps
module tio_trigger #(
  parameter int DEB_CYC = tio_pkg::DEB_CYCLES,
  parameter int HOLD_CYC = tio_pkg::HOLD_CYCLES
) (
  input wire logic sys_clk_in, // 40 MHz system clock
  input wire logic sys_rst_in, // async reset, active high
  input wire logic [tio_pkg::NUM_IN-1:0] input_line_in, // pins, pulled up outside, async
  input wire logic alarm_button_n_in, // onboard guarded button, low when pressed, async
  input wire logic cfg_wr_in, // strobe: load role and trigger word
  input wire tio_pkg::tio_cfg_t cfg_in, // role and trigger word
  input wire logic cfg_default_in, // strobe: apply configuration defaults
  input wire logic alarm_switch_type_cmd_in, // strobe: set switch type
  input wire logic alarm_switch_latch_in, // 1 latching, 0 momentary
  input wire logic pin_change_report_cmd_in, // strobe: set change reporting
  input wire logic pin_change_report_en_in, // reporting enable value
  input wire logic output_level_cmd_in, // strobe: set one output
  input wire logic [1:0] output_sel_in, // output index 0..2
  input wire logic output_val_in, // level for that output
  input wire logic remote_update_in, // strobe: remote update of all outputs
  input wire logic [tio_pkg::NUM_OUT-1:0] remote_levels_in, // levels from remote update
  input wire logic baud_rate_cmd_in, // strobe: change baud rate
  input wire logic [2:0] baud_sel_in, // rate index 0..5
  output logic emergency_active_out, // emergency tracking active
  output logic alarm_lamp_out, // emergency lamp drive
  output logic test_start_out, // pulse: enter test tracking
  output logic [tio_pkg::NUM_IN-1:0] input_report_out, // pulse per line: queue input report
  output logic pin_value_notice_out, // pulse: send level notice
  output logic [tio_pkg::NUM_IN-1:0] input_levels_out, // current debounced levels
  output logic [tio_pkg::NUM_OUT-1:0] output_line_out, // logic outputs
  output logic [2:0] baud_sel_out, // active rate index
  output logic [15:0] baud_div_out, // clocks per bit at active rate
  output logic baud_reject_out // pulse: rate command out of range
);
  localparam int NI = tio_pkg::NUM_IN;
  localparam int NSRC = NI + 1;
  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 2);
  localparam logic [15:0] DIV_RST = 16'(tio_pkg::baud_div(int'(tio_pkg::TIO_BAUD_DEFAULT)));

  // refuse settings the counters cannot serve
  if (DEB_CYC < 1 || HOLD_CYC < 1) begin : g_bad_count
    $error("tio_trigger: counts must be at least one");
  end
  if (tio_pkg::baud_div(0) > 65535) begin : g_bad_div
    $error("tio_trigger: baud divisor exceeds 16 bits");
  end

  // two-stage synchronisers, reset high as the pull-ups would read
  logic [NSRC-1:0] sync1;
  logic [NSRC-1:0] sync2;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= {alarm_button_n_in, input_line_in};
      sync2 <= sync1;
    end
  end

  // debounce: a level is accepted after DEB_CYC stable cycles; bounces restart the count
  logic [NSRC-1:0] deb;
  for (genvar i = 0; i < NSRC; i++) begin : g_deb
    logic [DW-1:0] cnt;
    logic [DW-1:0] next_cnt;
    logic lvl;
    logic next_lvl;
    always_comb begin
      next_cnt = cnt;
      next_lvl = lvl;
      if (sync2[i] == lvl) begin
        next_cnt = '0;
      end else if (cnt == DW'(DEB_CYC - 1)) begin
        next_cnt = '0;
        next_lvl = sync2[i];
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        cnt <= '0;
        lvl <= 1'b1;
      end else begin
        cnt <= next_cnt;
        lvl <= next_lvl;
      end
    end
    assign deb[i] = lvl;
  end

  // configuration state
  tio_pkg::tio_cfg_t cfg, next_cfg;
  tio_pkg::tio_sw_t sw_type, next_sw_type;
  logic pcr_en, next_pcr_en;
  always_comb begin
    next_cfg = cfg;
    next_sw_type = sw_type;
    next_pcr_en = pcr_en;
    if (cfg_default_in) begin
      next_cfg = tio_pkg::TIO_CFG_DEFAULT;
      next_sw_type = tio_pkg::TIO_SW_DEFAULT;
      next_pcr_en = tio_pkg::TIO_PCR_DEFAULT;
    end else begin
      if (cfg_wr_in) begin
        next_cfg = cfg_in;
      end
      if (alarm_switch_type_cmd_in) begin
        next_sw_type = alarm_switch_latch_in ? tio_pkg::TIO_SW_LATCH : tio_pkg::TIO_SW_MOMENT;
      end
      if (pin_change_report_cmd_in) begin
        next_pcr_en = pin_change_report_en_in;
      end
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg <= tio_pkg::TIO_CFG_DEFAULT;
      sw_type <= tio_pkg::TIO_SW_DEFAULT;
      pcr_en <= tio_pkg::TIO_PCR_DEFAULT;
    end else begin
      cfg <= next_cfg;
      sw_type <= next_sw_type;
      pcr_en <= next_pcr_en;
    end
  end

  // per-line edge match and latching level; line zero's level also sees the button
  logic [NI-1:0] prev;
  logic [NI-1:0] hit;
  logic [NI-1:0] hold_lvl;
  logic [NI-1:0] is_em;
  logic [NI-1:0] is_te;
  logic [NI-1:0] is_ge;
  for (genvar i = 0; i < NI; i++) begin : g_line
    logic rise;
    logic fall;
    logic lvl;
    assign rise = deb[i] & ~prev[i];
    assign fall = ~deb[i] & prev[i];
    assign lvl = (i == 0) ? (deb[i] & deb[NI]) : deb[i];
    assign hit[i] = (cfg.trig[i] == tio_pkg::TIO_TRIG_RISE) ? rise :
                    (cfg.trig[i] == tio_pkg::TIO_TRIG_FALL) ? fall : (rise | fall);
    assign hold_lvl[i] = (cfg.trig[i] == tio_pkg::TIO_TRIG_RISE) ? lvl : ~lvl;
    assign is_em[i] = cfg.role[i] == tio_pkg::TIO_ROLE_EMERG;
    assign is_te[i] = cfg.role[i] == tio_pkg::TIO_ROLE_TEST;
    assign is_ge[i] = cfg.role[i] == tio_pkg::TIO_ROLE_GEN;
  end

  // button press timer: in momentary mode a short release starts, long hold stops emergency
  tio_pkg::tio_btn_t btn, next_btn;
  logic [HW-1:0] hold_cnt, next_hold_cnt;
  logic btn_short;
  logic btn_long;
  always_comb begin
    next_btn = btn;
    next_hold_cnt = hold_cnt;
    btn_short = 1'b0;
    btn_long = 1'b0;
    unique case (btn)
      tio_pkg::TIO_BTN_UP: begin
        next_hold_cnt = '0;
        if (!deb[NI]) begin
          next_btn = tio_pkg::TIO_BTN_DOWN;
        end
      end
      tio_pkg::TIO_BTN_DOWN: begin
        if (deb[NI]) begin
          next_btn = tio_pkg::TIO_BTN_UP;
          btn_short = 1'b1;
        end else if (hold_cnt == HW'(HOLD_CYC)) begin
          next_btn = tio_pkg::TIO_BTN_LONG;
          btn_long = 1'b1;
        end else begin
          next_hold_cnt = hold_cnt + 1'b1;
        end
      end
      tio_pkg::TIO_BTN_LONG: begin
        if (deb[NI]) begin
          next_btn = tio_pkg::TIO_BTN_UP;
        end
      end
      default: begin
        next_btn = tio_pkg::TIO_BTN_UP;
      end
    endcase
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      btn <= tio_pkg::TIO_BTN_UP;
      hold_cnt <= '0;
    end else begin
      btn <= next_btn;
      hold_cnt <= next_hold_cnt;
    end
  end

  // emergency, events and notices
  logic emerg, next_emerg;
  logic test_go, next_test_go;
  logic [NI-1:0] report, next_report;
  logic notice, next_notice;
  logic [NI-1:0] levels, next_levels;
  logic latch_cond;
  assign latch_cond = |(hold_lvl & is_em);
  always_comb begin
    next_emerg = emerg;
    if (sw_type == tio_pkg::TIO_SW_LATCH) begin
      next_emerg = latch_cond;
    end else if (emerg && btn_long) begin
      next_emerg = 1'b0;
    end else if (|(hit & is_em) || btn_short) begin
      next_emerg = 1'b1;
    end
    next_test_go = |(hit & is_te);
    next_report = hit & is_ge;
    next_notice = pcr_en && (deb[NI-1:0] != prev);
    next_levels = deb[NI-1:0];
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev <= '1;
      emerg <= 1'b0;
      test_go <= 1'b0;
      report <= '0;
      notice <= 1'b0;
      levels <= '1;
    end else begin
      prev <= deb[NI-1:0];
      emerg <= next_emerg;
      test_go <= next_test_go;
      report <= next_report;
      notice <= next_notice;
      levels <= next_levels;
    end
  end
  assign emergency_active_out = emerg;
  assign alarm_lamp_out = emerg;
  assign test_start_out = test_go;
  assign input_report_out = report;
  assign pin_value_notice_out = notice;
  assign input_levels_out = levels;

  // outputs and baud rate; a remote update lands after a same-cycle host command
  logic [15:0] div_tab [tio_pkg::NUM_BAUD];
  for (genvar b = 0; b < tio_pkg::NUM_BAUD; b++) begin : g_div
    assign div_tab[b] = 16'(tio_pkg::baud_div(b));
  end
  logic [tio_pkg::NUM_OUT-1:0] outs, next_outs;
  logic [2:0] bsel, next_bsel;
  logic [15:0] bdiv, next_bdiv;
  logic brej, next_brej;
  always_comb begin
    next_outs = outs;
    next_bsel = bsel;
    next_brej = 1'b0;
    if (output_level_cmd_in && output_sel_in < 2'(tio_pkg::NUM_OUT)) begin
      next_outs[output_sel_in] = output_val_in;
    end
    if (remote_update_in) begin
      next_outs = remote_levels_in;
    end
    if (baud_rate_cmd_in) begin
      if (baud_sel_in <= tio_pkg::TIO_BAUD_MAX) begin
        next_bsel = baud_sel_in;
      end else begin
        next_brej = 1'b1;
      end
    end
    next_bdiv = div_tab[next_bsel];
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      outs <= tio_pkg::TIO_OUT_DEFAULT;
      bsel <= tio_pkg::TIO_BAUD_DEFAULT;
      bdiv <= DIV_RST;
      brej <= 1'b0;
    end else begin
      outs <= next_outs;
      bsel <= next_bsel;
      bdiv <= next_bdiv;
      brej <= next_brej;
    end
  end
  assign output_line_out = outs;
  assign baud_sel_out = bsel;
  assign baud_div_out = bdiv;
  assign baud_reject_out = brej;

  // checks
  sequence s_short_press;
    btn == tio_pkg::TIO_BTN_DOWN ##1 btn == tio_pkg::TIO_BTN_UP;
  endsequence
  sequence s_momentary_idle;
    sw_type == tio_pkg::TIO_SW_MOMENT && !emerg && btn == tio_pkg::TIO_BTN_DOWN && deb[NI];
  endsequence

  a_short_start: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_momentary_idle |-> ##1 (emerg && alarm_lamp_out && btn == tio_pkg::TIO_BTN_UP))
    else $error("short button press did not start emergency");
  a_short_seq: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_short_press |-> emerg || $past(sw_type) == tio_pkg::TIO_SW_LATCH)
    else $error("released press left emergency off");
  a_long_stop: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (sw_type == tio_pkg::TIO_SW_MOMENT && emerg && btn_long && !cfg_default_in && !alarm_switch_type_cmd_in)
    |=> !emerg ##1 (btn == tio_pkg::TIO_BTN_LONG || btn == tio_pkg::TIO_BTN_UP))
    else $error("long hold did not end emergency");
  a_long_timing: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    btn_long |-> hold_cnt == HW'(HOLD_CYC) && $past(btn) == tio_pkg::TIO_BTN_DOWN)
    else $error("long hold flagged at wrong count");
  a_latch_level: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (sw_type == tio_pkg::TIO_SW_LATCH) |=> emerg == $past(latch_cond))
    else $error("latching emergency does not follow trigger level");
  a_lamp_match: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    alarm_lamp_out == emergency_active_out)
    else $error("lamp not lit with emergency");
  a_test_pulse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    |(hit & is_te) |=> test_start_out ##1 (test_start_out == $past(|(hit & is_te))))
    else $error("test trigger not passed on");
  a_report_pulse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    input_report_out != '0 |-> $past(hit & is_ge) == input_report_out)
    else $error("input report without general trigger");
  a_notice_cause: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    pin_value_notice_out |-> $past(pcr_en) && input_levels_out != $past(input_levels_out))
    else $error("notice without enabled level change");
  a_baud_range: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (baud_rate_cmd_in && baud_sel_in > tio_pkg::TIO_BAUD_MAX) |=> baud_reject_out && $stable(baud_sel_out))
    else $error("out of range rate accepted");
  a_default_cfg: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    cfg_default_in |=> cfg.role[0] == tio_pkg::TIO_ROLE_EMERG && cfg.role[1] == tio_pkg::TIO_ROLE_TEST
      && cfg.trig[0] == tio_pkg::TIO_TRIG_FALL && cfg.trig[1] == tio_pkg::TIO_TRIG_FALL
      && sw_type == tio_pkg::TIO_SW_MOMENT)
    else $error("defaults not applied");
endmodule

// ==== verif/tio_field_model.sv ====
// tio_field_model: external switches and onboard button in front of the connector inputs
`timescale 1ns/10ps
module tio_field_model (
  input wire logic [3:0] pull_low_in, // bench asks a switch to pull a line low
  input wire logic press_in, // bench asks the guarded button to be pressed
  output logic [3:0] line_out, // connector input levels
  output logic button_n_out // button level, low when pressed
);
  // a released switch leaves the line to the pull-up, so it reads high
  assign line_out = ~pull_low_in;
  // the button shorts to ground while pressed
  assign button_n_out = ~press_in;
endmodule

// ==== verif/testbench.sv ====
// testbench: self-checking bench for the tracker input/output trigger logic
`timescale 1ns/10ps
module testbench;
  localparam int DEB = 4;
  localparam int HOLD = 50;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] pull_low = 4'h0;
  logic btn_press = 1'b0;
  logic [3:0] line_w;
  logic btn_n_w;
  logic cfg_wr = 1'b0;
  tio_pkg::tio_cfg_t cfg = tio_pkg::TIO_CFG_DEFAULT;
  logic cfg_def = 1'b0, sw_cmd = 1'b0, sw_latch = 1'b0, pcr_cmd = 1'b0, pcr_en = 1'b0;
  logic out_cmd = 1'b0, out_val = 1'b0, rem_upd = 1'b0, baud_cmd = 1'b0;
  logic [1:0] out_sel = 2'h0;
  logic [2:0] rem_lv = 3'h0;
  logic [2:0] baud_sel = 3'h0;
  logic emerg, lamp, test_st, notice, brej;
  logic [3:0] rep, lvls;
  logic [3:0] notice_lv = 4'h0;
  logic [2:0] outl, bsel;
  logic [15:0] bdiv;
  int err_total = 0, n_tests = 0, cycles = 0, n_test_st = 0, n_notice = 0;
  int n_rep [4] = '{0, 0, 0, 0};

  tio_field_model FIELD (.pull_low_in(pull_low), .press_in(btn_press), .line_out(line_w), .button_n_out(btn_n_w));
  tio_trigger #(.DEB_CYC(DEB), .HOLD_CYC(HOLD)) DUT (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .input_line_in(line_w), .alarm_button_n_in(btn_n_w),
    .cfg_wr_in(cfg_wr), .cfg_in(cfg), .cfg_default_in(cfg_def), .alarm_switch_type_cmd_in(sw_cmd),
    .alarm_switch_latch_in(sw_latch), .pin_change_report_cmd_in(pcr_cmd), .pin_change_report_en_in(pcr_en),
    .output_level_cmd_in(out_cmd), .output_sel_in(out_sel), .output_val_in(out_val), .remote_update_in(rem_upd),
    .remote_levels_in(rem_lv), .baud_rate_cmd_in(baud_cmd), .baud_sel_in(baud_sel),
    .emergency_active_out(emerg), .alarm_lamp_out(lamp), .test_start_out(test_st), .input_report_out(rep),
    .pin_value_notice_out(notice), .input_levels_out(lvls), .output_line_out(outl), .baud_sel_out(bsel),
    .baud_div_out(bdiv), .baud_reject_out(brej));

  always #12.5 sys_clk_in = ~sys_clk_in;

  // pulses stand one cycle; counted at the falling edge, where they are settled; also cuts a hang short
  always @(negedge sys_clk_in) begin
    cycles++;
    if (test_st === 1'b1) n_test_st++;
    if (notice === 1'b1) begin
      n_notice++;
      notice_lv = lvls;
    end
    for (int i = 0; i < 4; i++) if (rep[i] === 1'b1) n_rep[i]++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  // pin change, then wait out sync, debounce and the output register
  task automatic pin(input int i, input logic low);
    pull_low[i] = low;
    cyc(DEB + 12);
  endtask

  task automatic hold_button(input int n);
    btn_press = 1'b1;
    cyc(n);
    btn_press = 1'b0;
    cyc(DEB + 12);
  endtask

  task automatic t_reset();
    chk(emerg, 0, "emergency after reset");
    chk(lamp, 0, "lamp after reset");
    chk(lvls, 4'hf, "levels after reset");
    chk(outl, 0, "outputs after reset");
    chk(bsel, 2, "baud index after reset");
    chk(bdiv, 2083, "baud divider after reset");
  endtask

  task automatic t_defaults();
    pin(1, 1'b1);
    chk(n_test_st, 1, "test start on line one fall");
    chk(emerg, 0, "test line does not start emergency");
    pin(1, 1'b0);
    chk(n_test_st, 1, "no test start on rise");
    pin(0, 1'b1);
    chk(emerg, 1, "emergency on line zero fall");
    chk(lamp, 1, "lamp lit");
    pin(0, 1'b0);
    chk(emerg, 1, "momentary stays active after line rise");
  endtask

  // long hold ends emergency; a short press only acts on release
  task automatic t_button();
    hold_button(HOLD + 30);
    chk(emerg, 0, "long hold ends emergency");
    chk(lamp, 0, "lamp off");
    btn_press = 1'b1;
    cyc(DEB + 8);
    chk(emerg, 0, "press alone does not start");
    btn_press = 1'b0;
    cyc(DEB + 12);
    chk(emerg, 1, "press and release starts emergency");
    hold_button(HOLD + 30);
    chk(emerg, 0, "second long hold ends emergency");
  endtask

  task automatic t_general();
    int base;
    tio_pkg::tio_trig_t tr [3] = '{tio_pkg::TIO_TRIG_RISE, tio_pkg::TIO_TRIG_FALL, tio_pkg::TIO_TRIG_BOTH};
    for (int k = 0; k < 3; k++) begin
      cfg = tio_pkg::TIO_CFG_DEFAULT;
      cfg.trig[3] = tr[k];
      cfg_wr = 1'b1;
      cyc(1);
      cfg_wr = 1'b0;
      cyc(2);
      base = n_rep[3];
      pin(3, 1'b1);
      pin(3, 1'b0);
      chk(n_rep[3] - base, (k == 2) ? 2 : 1, "general reports per fall and rise");
    end
    cfg_def = 1'b1;
    cyc(1);
    cfg_def = 1'b0;
    cyc(2);
  endtask

  task automatic t_notice();
    int base;
    pcr_en = 1'b1;
    pcr_cmd = 1'b1;
    cyc(1);
    pcr_cmd = 1'b0;
    base = n_notice;
    pin(2, 1'b1);
    chk(n_notice - base, 1, "notice on change");
    chk(notice_lv, 4'hb, "notice carries levels");
    chk(lvls, 4'hb, "levels of a general line");
    pin(2, 1'b0);
    chk(notice_lv, 4'hf, "notice after return");
    pcr_en = 1'b0;
    pcr_cmd = 1'b1;
    cyc(1);
    pcr_cmd = 1'b0;
    pin(2, 1'b1);
    pin(2, 1'b0);
    chk(n_notice - base, 2, "no notice while reporting off");
  endtask

  task automatic t_latch();
    sw_latch = 1'b1;
    sw_cmd = 1'b1;
    cyc(1);
    sw_cmd = 1'b0;
    pin(0, 1'b1);
    chk(emerg, 1, "latching active while low");
    chk(lamp, 1, "lamp in latching");
    pin(0, 1'b0);
    chk(emerg, 0, "latching ends on return high");
    sw_latch = 1'b0;
    sw_cmd = 1'b1;
    cyc(1);
    sw_cmd = 1'b0;
    cyc(2);
  endtask

  task automatic t_outputs();
    out_val = 1'b1;
    for (int i = 0; i < 4; i++) begin
      out_sel = 2'(i);
      out_cmd = 1'b1;
      cyc(1);
      out_cmd = 1'b0;
      cyc(2);
      chk(outl, (i < 3) ? (1 << (i + 1)) - 1 : 7, "host output level");
    end
    rem_lv = 3'h5;
    rem_upd = 1'b1;
    cyc(1);
    rem_upd = 1'b0;
    cyc(2);
    chk(outl, 3'h5, "remote update of outputs");
  endtask

  task automatic t_baud();
    for (int i = 0; i < 6; i++) begin
      baud_sel = 3'(i);
      baud_cmd = 1'b1;
      cyc(1);
      baud_cmd = 1'b0;
      cyc(1);
      chk(bsel, i, "baud index");
      chk(bdiv, 40000000 / tio_pkg::BAUD_RATE[i], "baud divider");
    end
    baud_sel = 3'h6;
    baud_cmd = 1'b1;
    cyc(1);
    baud_cmd = 1'b0;
    chk(brej, 1, "out of range rate refused");
    cyc(1);
    chk(bdiv, 347, "rate unchanged after refusal");
  endtask

  initial begin
    cyc(16);
    sys_rst_in = 1'b0;
    cyc(2);
    t_reset();
    t_defaults();
    t_button();
    t_general();
    t_notice();
    t_latch();
    t_outputs();
    t_baud();
    end_of_test();
  end
endmodule
